//--- fwg_pkg.sv
// Package: constants and types for the flash write guard and page lock
package fwg_pkg;
   // ==========================================================
   // Geometry
   localparam int          FWG_ADDR_W        = 14;
   localparam int          FWG_PAGE_BITS     = 9;
   localparam int          FWG_PAGE_W        = FWG_ADDR_W - FWG_PAGE_BITS;
   localparam logic [13:0] FWG_PAGE0_FIRST   = 14'h0000;
   localparam logic [13:0] FWG_PAGE0_LAST    = 14'h01FF;
   localparam logic [13:0] FWG_LOCK_ADDR     = 14'h3FFF;
   // ==========================================================
   // Values after reset
   localparam logic [7:0]  FWG_LOCK_RST      = 8'hFF;
   localparam logic [7:0]  FWG_DATA_RST      = 8'h00;
   // ==========================================================
   // Sequencer states
   typedef enum logic [1:0] {
      FWG_IDLE  = 2'b00,
      FWG_BOOT  = 2'b01,
      FWG_WAIT  = 2'b10,
      FWG_RUN   = 2'b11
   } fwg_state_e;
endpackage

//--- fwg_lock_decode.sv
// Lock decoder: tells whether an address falls in a locked page
module fwg_lock_decode
   import fwg_pkg::*;
(
   // Lock setting and address
   input  wire logic [7:0]            lock_byte_in,
   input  wire logic [FWG_ADDR_W-1:0] addr_in,
   // Result
   output logic                       locked_out
);
   logic [7:0]            count_w;
   logic [FWG_PAGE_W-1:0] page_w;
   logic [FWG_PAGE_W-1:0] lock_page_w;
   assign count_w     = ~lock_byte_in;
   assign page_w      = addr_in[FWG_ADDR_W-1:FWG_PAGE_BITS];
   assign lock_page_w = FWG_LOCK_ADDR[FWG_ADDR_W-1:FWG_PAGE_BITS];
   // Pages 0..n-1 locked; lock byte page locked whenever n is nonzero
   assign locked_out  = ({3'h0, page_w} < count_w) ||
                        ((page_w == lock_page_w) && (count_w != 8'h00));
endmodule

//--- fwg_access_gate.sv
// Access gate: qualifies a single flash request against enables and lock
module fwg_access_gate (
   // Request qualifiers
   input  wire logic is_write_in,
   input  wire logic is_erase_in,
   input  wire logic write_en_in,
   input  wire logic erase_en_in,
   input  wire logic protected_in,
   input  wire logic page_locked_in,
   // Result
   output logic      allow_out
);
   logic lock_ok_w;
   assign lock_ok_w = protected_in || !page_locked_in;
   assign allow_out = lock_ok_w &&
                      (!is_write_in || write_en_in) &&
                      (!is_erase_in || (write_en_in && erase_en_in));
endmodule

//--- fwg_top.sv
// Top: flash write guard and page lock between core, debug port and flash
module fwg_top
   import fwg_pkg::*;
(
   // Clock and reset
   input  wire logic                  ref_clk_in,
   input  wire logic                  reset_in,
   // Program store control bits
   input  wire logic                  flash_write_enable_in,
   input  wire logic                  flash_erase_enable_in,
   // Core external move instruction
   input  wire logic                  ext_req_in,
   input  wire logic                  ext_wr_in,
   input  wire logic                  ext_prot_in,
   input  wire logic [FWG_ADDR_W-1:0] ext_addr_in,
   input  wire logic [7:0]            ext_wdata_in,
   // Core code move instruction
   input  wire logic                  code_rd_in,
   input  wire logic                  code_prot_in,
   input  wire logic [FWG_ADDR_W-1:0] code_addr_in,
   // Debug two wire port requests
   input  wire logic                  dbg_req_in,
   input  wire logic [1:0]            dbg_op_in,
   input  wire logic [FWG_ADDR_W-1:0] dbg_addr_in,
   input  wire logic [7:0]            dbg_wdata_in,
   // Flash array interface
   input  wire logic [7:0]            flash_rdata_in,
   output logic                       flash_rd_out,
   output logic                       flash_wr_out,
   output logic                       flash_erase_out,
   output logic [FWG_ADDR_W-1:0]      flash_addr_out,
   output logic [7:0]                 flash_wdata_out,
   // External data RAM interface
   output logic                       external_data_ram_rd_out,
   output logic                       external_data_ram_wr_out,
   output logic [FWG_ADDR_W-1:0]      external_data_ram_addr_out,
   output logic [7:0]                 external_data_ram_wdata_out,
   // Answers
   output logic [7:0]                 code_rdata_out,
   output logic                       code_valid_out,
   output logic [7:0]                 dbg_rdata_out,
   output logic                       dbg_valid_out,
   output logic                       denied_out,
   output logic                       lock_ready_out
);
   import fwg_pkg::*;

   // ==========================================================
   // Debug operation codes
   localparam logic [1:0] DBG_READ  = 2'h0;
   localparam logic [1:0] DBG_WRITE = 2'h1;
   localparam logic [1:0] DBG_ERASE = 2'h2;

   // ==========================================================
   // Lock byte load sequencer
   // Lock byte is fetched once after reset; until then every page counts as locked.
   fwg_state_e      state_q, state_d;
   logic [7:0]      lock_q, lock_d;
   logic            lock_rdy_q, lock_rdy_d;

   // ==========================================================
   // Registered outputs
   logic            f_rd_q, f_rd_d;
   logic            f_wr_q, f_wr_d;
   logic            f_er_q, f_er_d;
   logic [FWG_ADDR_W-1:0] f_addr_q, f_addr_d;
   logic [7:0]      f_wdat_q, f_wdat_d;
   logic            x_rd_q, x_rd_d;
   logic            x_wr_q, x_wr_d;
   logic [FWG_ADDR_W-1:0] x_addr_q, x_addr_d;
   logic [7:0]      x_wdat_q, x_wdat_d;
   logic [7:0]      c_dat_q, c_dat_d;
   logic            c_val_q, c_val_d;
   logic [7:0]      d_dat_q, d_dat_d;
   logic            d_val_q, d_val_d;
   logic            den_q, den_d;
   // Pending read answers: flash data is taken while the read strobe is out, answer valid next cycle
   logic            c_pend_q, c_pend_d;
   logic            d_pend_q, d_pend_d;

   // ==========================================================
   // Decode and gating
   logic            ext_lock_w, code_lock_w, dbg_lock_w;
   logic            ext_allow_w, code_allow_w, dbg_allow_w;
   logic [7:0]      eff_lock_w;
   logic            dbg_wr_w, dbg_er_w, ext_er_w;

   // Unknown lock until loaded: treat as fully locked
   assign eff_lock_w = lock_rdy_q ? lock_q : 8'h00;
   // Erase by software: external write aimed at the erase path when erase enable set
   assign ext_er_w   = flash_erase_enable_in;
   assign dbg_wr_w   = (dbg_op_in == DBG_WRITE);
   assign dbg_er_w   = (dbg_op_in == DBG_ERASE);

   fwg_lock_decode u_ext_dec (
      .lock_byte_in (eff_lock_w),
      .addr_in      (ext_addr_in),
      .locked_out   (ext_lock_w)
   );
   fwg_lock_decode u_code_dec (
      .lock_byte_in (eff_lock_w),
      .addr_in      (code_addr_in),
      .locked_out   (code_lock_w)
   );
   fwg_lock_decode u_dbg_dec (
      .lock_byte_in (eff_lock_w),
      .addr_in      (dbg_addr_in),
      .locked_out   (dbg_lock_w)
   );

   fwg_access_gate u_ext_gate (
      .is_write_in    (1'b1),
      .is_erase_in    (ext_er_w),
      .write_en_in    (flash_write_enable_in),
      .erase_en_in    (flash_erase_enable_in),
      .protected_in   (ext_prot_in),
      .page_locked_in (ext_lock_w),
      .allow_out      (ext_allow_w)
   );
   fwg_access_gate u_code_gate (
      .is_write_in    (1'b0),
      .is_erase_in    (1'b0),
      .write_en_in    (1'b0),
      .erase_en_in    (1'b0),
      .protected_in   (code_prot_in),
      .page_locked_in (code_lock_w),
      .allow_out      (code_allow_w)
   );
   // Debug port is never a protected source; enables do not apply to it
   fwg_access_gate u_dbg_gate (
      .is_write_in    (1'b0),
      .is_erase_in    (1'b0),
      .write_en_in    (1'b0),
      .erase_en_in    (1'b0),
      .protected_in   (1'b0),
      .page_locked_in (dbg_lock_w),
      .allow_out      (dbg_allow_w)
   );

   // ==========================================================
   // Next state
   always_comb begin
      state_d    = state_q;
      lock_d     = lock_q;
      lock_rdy_d = lock_rdy_q;
      f_rd_d     = 1'b0;
      f_wr_d     = 1'b0;
      f_er_d     = 1'b0;
      f_addr_d   = f_addr_q;
      f_wdat_d   = f_wdat_q;
      x_rd_d     = 1'b0;
      x_wr_d     = 1'b0;
      x_addr_d   = x_addr_q;
      x_wdat_d   = x_wdat_q;
      c_dat_d    = c_dat_q;
      c_val_d    = 1'b0;
      d_dat_d    = d_dat_q;
      d_val_d    = 1'b0;
      den_d      = 1'b0;
      c_pend_d   = 1'b0;
      d_pend_d   = 1'b0;

      // Returning read data
      if (c_pend_q) begin
         c_dat_d = flash_rdata_in;
         c_val_d = 1'b1;
      end
      if (d_pend_q) begin
         d_dat_d = flash_rdata_in;
         d_val_d = 1'b1;
      end

      case (state_q)
         FWG_IDLE: begin
            state_d = FWG_BOOT;
         end
         FWG_BOOT: begin
            f_rd_d   = 1'b1;
            f_addr_d = FWG_LOCK_ADDR;
            state_d  = FWG_WAIT;
         end
         FWG_WAIT: begin
            // Strobe registered in BOOT is out this cycle, data is valid now
            lock_d     = flash_rdata_in;
            lock_rdy_d = 1'b1;
            state_d    = FWG_RUN;
         end
         FWG_RUN: begin
            // External reads always go to RAM, never flash
            if (ext_req_in && !ext_wr_in) begin
               x_rd_d   = 1'b1;
               x_addr_d = ext_addr_in;
            end
            // One flash port: core external write first, then code read, then debug
            if (ext_req_in && ext_wr_in) begin
               if (ext_allow_w) begin
                  f_wr_d   = !flash_erase_enable_in;
                  f_er_d   = flash_erase_enable_in;
                  f_addr_d = ext_addr_in;
                  f_wdat_d = ext_wdata_in;
               end else begin
                  den_d = 1'b1;
               end
            end else if (code_rd_in) begin
               if (code_allow_w) begin
                  f_rd_d   = 1'b1;
                  f_addr_d = code_addr_in;
                  c_pend_d = 1'b1;
               end else begin
                  den_d   = 1'b1;
                  c_dat_d = FWG_DATA_RST;
                  c_val_d = 1'b1;
               end
            end else if (dbg_req_in) begin
               if (dbg_allow_w) begin
                  f_rd_d   = (dbg_op_in == DBG_READ);
                  f_wr_d   = dbg_wr_w;
                  f_er_d   = dbg_er_w;
                  f_addr_d = dbg_addr_in;
                  f_wdat_d = dbg_wdata_in;
                  d_pend_d = (dbg_op_in == DBG_READ);
               end else begin
                  den_d   = 1'b1;
                  d_dat_d = FWG_DATA_RST;
                  d_val_d = (dbg_op_in == DBG_READ);
               end
            end
            // Lock byte tracks writes to its own location
            if (f_wr_d && (f_addr_d == FWG_LOCK_ADDR)) begin
               lock_d = lock_q & f_wdat_d;
            end
            if (f_er_d && (f_addr_d[FWG_ADDR_W-1:FWG_PAGE_BITS] ==
                           FWG_LOCK_ADDR[FWG_ADDR_W-1:FWG_PAGE_BITS])) begin
               lock_d = FWG_LOCK_RST;
            end
         end
         default: begin
            state_d = FWG_IDLE;
         end
      endcase
   end

   // ==========================================================
   // Registers
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         state_q    <= FWG_IDLE;
         lock_q     <= FWG_LOCK_RST;
         lock_rdy_q <= 1'b0;
         f_rd_q     <= 1'b0;
         f_wr_q     <= 1'b0;
         f_er_q     <= 1'b0;
         f_addr_q   <= FWG_PAGE0_FIRST;
         f_wdat_q   <= FWG_DATA_RST;
         x_rd_q     <= 1'b0;
         x_wr_q     <= 1'b0;
         x_addr_q   <= FWG_PAGE0_FIRST;
         x_wdat_q   <= FWG_DATA_RST;
         c_dat_q    <= FWG_DATA_RST;
         c_val_q    <= 1'b0;
         d_dat_q    <= FWG_DATA_RST;
         d_val_q    <= 1'b0;
         den_q      <= 1'b0;
         c_pend_q   <= 1'b0;
         d_pend_q   <= 1'b0;
      end else begin
         state_q    <= state_d;
         lock_q     <= lock_d;
         lock_rdy_q <= lock_rdy_d;
         f_rd_q     <= f_rd_d;
         f_wr_q     <= f_wr_d;
         f_er_q     <= f_er_d;
         f_addr_q   <= f_addr_d;
         f_wdat_q   <= f_wdat_d;
         x_rd_q     <= x_rd_d;
         x_wr_q     <= x_wr_d;
         x_addr_q   <= x_addr_d;
         x_wdat_q   <= x_wdat_d;
         c_dat_q    <= c_dat_d;
         c_val_q    <= c_val_d;
         d_dat_q    <= d_dat_d;
         d_val_q    <= d_val_d;
         den_q      <= den_d;
         c_pend_q   <= c_pend_d;
         d_pend_q   <= d_pend_d;
      end
   end

   assign flash_rd_out    = f_rd_q;
   assign flash_wr_out    = f_wr_q;
   assign flash_erase_out = f_er_q;
   assign flash_addr_out  = f_addr_q;
   assign flash_wdata_out = f_wdat_q;
   assign external_data_ram_rd_out     = x_rd_q;
   assign external_data_ram_wr_out     = x_wr_q;
   assign external_data_ram_addr_out   = x_addr_q;
   assign external_data_ram_wdata_out  = x_wdat_q;
   assign code_rdata_out  = c_dat_q;
   assign code_valid_out  = c_val_q;
   assign dbg_rdata_out   = d_dat_q;
   assign dbg_valid_out   = d_val_q;
   assign denied_out      = den_q;
   assign lock_ready_out  = lock_rdy_q;
endmodule

//--- fwg_top_properties.sv
// Checker: port-level properties of the flash write guard
module fwg_top_properties
   import fwg_pkg::*;
(
   // Watched ports
   input wire logic                  ref_clk_in,
   input wire logic                  reset_in,
   input wire logic                  flash_write_enable_in,
   input wire logic                  flash_erase_enable_in,
   input wire logic                  ext_req_in,
   input wire logic                  ext_wr_in,
   input wire logic                  ext_prot_in,
   input wire logic [FWG_ADDR_W-1:0] ext_addr_in,
   input wire logic [7:0]            ext_wdata_in,
   input wire logic                  code_rd_in,
   input wire logic                  code_prot_in,
   input wire logic [FWG_ADDR_W-1:0] code_addr_in,
   input wire logic                  dbg_req_in,
   input wire logic [1:0]            dbg_op_in,
   input wire logic [FWG_ADDR_W-1:0] dbg_addr_in,
   input wire logic [7:0]            flash_rdata_in,
   input wire logic                  flash_rd_out,
   input wire logic                  flash_wr_out,
   input wire logic                  flash_erase_out,
   input wire logic [FWG_ADDR_W-1:0] flash_addr_out,
   input wire logic [7:0]            flash_wdata_out,
   input wire logic                  external_data_ram_rd_out,
   input wire logic                  external_data_ram_wr_out,
   input wire logic [FWG_ADDR_W-1:0] external_data_ram_addr_out,
   input wire logic [7:0]            code_rdata_out,
   input wire logic                  code_valid_out,
   input wire logic                  denied_out,
   input wire logic                  lock_ready_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] lk_q;
   logic [7:0] lk_d;
   logic       ewr;
   function automatic logic lkd(input logic [13:0] a, input logic [7:0] l);
      return ({3'h0, a[13:9]} < ~l) || (a[13:9] == 5'h1F && l != 8'hFF);
   endfunction
   // ==========================================================
   // Shadow of the lock byte, followed through flash strobes
   always_comb begin
      lk_d = lk_q;
      if (flash_rd_out && !lock_ready_out && flash_addr_out == FWG_LOCK_ADDR) begin
         lk_d = flash_rdata_in;
      end
      if (flash_wr_out && flash_addr_out == FWG_LOCK_ADDR) lk_d = lk_q & flash_wdata_out;
      if (flash_erase_out && flash_addr_out[13:9] == 5'h1F) lk_d = 8'hFF;
   end
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) lk_q <= 8'h00;
      else lk_q <= lk_d;
   end
   assign ewr = ext_req_in && ext_wr_in;
   // ==========================================================
   // Properties
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (reset_in);
   sequence s_wr(w, e);
      lock_ready_out && ewr && ext_prot_in && flash_write_enable_in == w
         && flash_erase_enable_in == e;
   endsequence
   sequence s_code(lk);
      lock_ready_out && !ewr && code_rd_in && !code_prot_in == lk && lkd(code_addr_in, lk_q) == lk;
   endsequence
   a_external_data_ram_no_write: assert property (!external_data_ram_wr_out)
      else $error("external RAM write strobe seen");
   a_ext_read_ram: assert property (lock_ready_out && ext_req_in && !ext_wr_in |=>
      external_data_ram_rd_out && external_data_ram_addr_out == $past(ext_addr_in))
      else $error("external read not sent to RAM");
   a_write_off_deny: assert property (lock_ready_out && ewr && !flash_write_enable_in
      |=> denied_out && !flash_wr_out && !flash_erase_out)
      else $error("write accepted with write enable clear");
   a_erase_both_on: assert property (s_wr(1'b1, 1'b1) |=> flash_erase_out
      && !flash_wr_out && flash_addr_out == $past(ext_addr_in))
      else $error("erase not issued with both enables");
   a_write_data: assert property (s_wr(1'b1, 1'b0) |=> flash_wr_out && !flash_erase_out
      && flash_wdata_out == $past(ext_wdata_in))
      else $error("enabled write not passed to flash");
   a_code_lock_deny: assert property (s_code(1'b1) |=> denied_out && code_valid_out
      && code_rdata_out == 8'h00 && !flash_rd_out)
      else $error("locked code read not refused");
   a_code_read_walk: assert property (s_code(1'b0) |=> flash_rd_out && !denied_out
      ##1 code_valid_out)
      else $error("allowed code read not served");
   a_dbg_lock_deny: assert property (lock_ready_out && !ewr && !code_rd_in
      && dbg_req_in && dbg_op_in != 2'h3 && lkd(dbg_addr_in, lk_q) |=> denied_out
      && !flash_rd_out && !flash_wr_out && !flash_erase_out)
      else $error("debug access to locked page not refused");
   a_lock_boot_read: assert property ($rose(lock_ready_out) |-> $past(flash_rd_out)
      && $past(flash_addr_out) == FWG_LOCK_ADDR)
      else $error("lock ready without reading the lock byte");
endmodule

bind fwg_top fwg_top_properties u_props (.ref_clk_in, .reset_in, .flash_write_enable_in,
   .flash_erase_enable_in, .ext_req_in, .ext_wr_in, .ext_prot_in, .ext_addr_in, .ext_wdata_in,
   .code_rd_in, .code_prot_in, .code_addr_in, .dbg_req_in, .dbg_op_in, .dbg_addr_in,
   .flash_rdata_in, .flash_rd_out, .flash_wr_out, .flash_erase_out, .flash_addr_out,
   .flash_wdata_out, .external_data_ram_rd_out, .external_data_ram_wr_out, .external_data_ram_addr_out, .code_rdata_out,
   .code_valid_out, .denied_out, .lock_ready_out);

//--- fwg_flash_model.sv
// Partner: byte-wide flash array answering the guard's strobes
module fwg_flash_model
   import fwg_pkg::*;
#(
   parameter logic [7:0] LOCK_INIT = 8'hFD
)
(
   // Clock
   input  wire logic                  ref_clk_in,
   // Strobes from the guard
   input  wire logic                  flash_rd_in,
   input  wire logic                  flash_wr_in,
   input  wire logic                  flash_erase_in,
   input  wire logic [FWG_ADDR_W-1:0] flash_addr_in,
   input  wire logic [7:0]            flash_wdata_in,
   // Read data
   output logic      [7:0]            flash_rdata_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [2**FWG_ADDR_W];
   logic [7:0] d_q = 8'h00;
   logic       h_q = 1'b0;
   initial begin
      foreach (mem[i]) mem[i] = i[7:0] ^ 8'h5A;
      mem[FWG_LOCK_ADDR] = LOCK_INIT;
   end
   // Data held one cycle past the strobe, then inverted so stale reads show
   assign flash_rdata_out = flash_rd_in ? mem[flash_addr_in] : (h_q ? d_q : ~d_q);
   always @(posedge ref_clk_in) begin
      h_q <= flash_rd_in;
      if (flash_rd_in) d_q <= mem[flash_addr_in];
      if (flash_wr_in) mem[flash_addr_in] <= mem[flash_addr_in] & flash_wdata_in;
      if (flash_erase_in) begin
         for (int j = 0; j < 512; j++) mem[{flash_addr_in[13:9], 9'(j)}] <= 8'hFF;
      end
   end
endmodule

//--- test_flash_write_guard_and_page_lock.sv
// Bench: guard checked against a reference model of enables and page lock
module test_flash_write_guard_and_page_lock;
   timeunit 1ns;
   timeprecision 1ns;
   import fwg_pkg::*;
   localparam logic [7:0]  LK0 = 8'hFD;
   localparam logic [13:0] BD [7] = '{14'h0000, 14'h01FF, 14'h0200, 14'h03FF, 14'h0400,
                                      14'h3E00, 14'h3FFF};
   logic        clk = 1'b0, rst = 1'b1, we = 1'b0, ee = 1'b0;
   logic        er = 1'b0, ew = 1'b0, ep = 1'b0, cr = 1'b0, cp = 1'b0, dr = 1'b0;
   logic [1:0]  dop = 2'h3;
   logic [13:0] ea = 14'h0, ca = 14'h0, da = 14'h0, fa, xa;
   logic [7:0]  ed = 8'h0, dd = 8'h0, frd, crd, drd, fwd, xwd, lk;
   logic        frs, fws, fes, xrs, xws, cv, dv, den, rdy;
   logic [7:0]  m [2**FWG_ADDR_W];
   logic [31:0] rs = 32'h3B16;
   int          error_cnt = 0;
   int          checked = 0;
   always #50 clk = ~clk;
   fwg_top dut (.ref_clk_in(clk), .reset_in(rst), .flash_write_enable_in(we),
      .flash_erase_enable_in(ee), .ext_req_in(er), .ext_wr_in(ew), .ext_prot_in(ep),
      .ext_addr_in(ea), .ext_wdata_in(ed), .code_rd_in(cr), .code_prot_in(cp), .code_addr_in(ca),
      .dbg_req_in(dr), .dbg_op_in(dop), .dbg_addr_in(da), .dbg_wdata_in(dd), .flash_rdata_in(frd),
      .flash_rd_out(frs), .flash_wr_out(fws), .flash_erase_out(fes), .flash_addr_out(fa),
      .flash_wdata_out(fwd), .external_data_ram_rd_out(xrs), .external_data_ram_wr_out(xws), .external_data_ram_addr_out(xa),
      .external_data_ram_wdata_out(xwd), .code_rdata_out(crd), .code_valid_out(cv), .dbg_rdata_out(drd),
      .dbg_valid_out(dv), .denied_out(den), .lock_ready_out(rdy));
   fwg_flash_model #(.LOCK_INIT(LK0)) flash (.ref_clk_in(clk), .flash_rd_in(frs),
      .flash_wr_in(fws), .flash_erase_in(fes), .flash_addr_in(fa), .flash_wdata_in(fwd),
      .flash_rdata_out(frd));
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      checked++;
      if (s !== e) begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   function automatic logic lkd(input int a);
      return (a / 512 < 255 - int'(lk)) || (a / 512 == 31 && lk != 8'hFF);
   endfunction
   // Kinds: 0 ext write, 1 ext read, 2 code read, 3..6 debug read, write, erase, none
   task automatic req(input int k, input logic [13:0] a, input logic [7:0] d, input logic p);
      logic ok, rd, wx, ex;
      ok = !lkd(a) || (p && k < 3);
      if (k == 0) ok = ok && we;
      rd = ok && (k == 2 || k == 3);
      wx = ok && (k == 0 && !ee || k == 4);
      ex = ok && (k == 0 && ee || k == 5);
      @(negedge clk);
      {er, ew, ep, ea, ed} = {k < 2, k == 0, p, a, d};
      {cr, cp, ca} = {k == 2, p, a};
      {dr, dop, da, dd} = {k > 2, 2'(k - 3), a, d};
      @(negedge clk);
      {er, cr, dr} = 3'h0;
      chk({frs, fws, fes, xrs, xws, den}, {rd, wx, ex, k == 1, 1'b0, !ok && k != 1});
      if (rd || wx || ex) chk(fa, a);
      if (wx) chk(fwd, d);
      if (k == 1) chk(xa, a);
      chk(xwd, 8'h00);
      chk({cv, dv}, {k == 2 && !ok, k == 3 && !ok});
      if (!ok && k == 2) chk(crd, 8'h00);
      if (!ok && k == 3) chk(drd, 8'h00);
      @(negedge clk);
      chk({cv, dv}, {k == 2 && rd, k == 3 && rd});
      if (rd) chk(k == 2 ? crd : drd, m[a]);
      if (wx) m[a] = m[a] & d;
      if (wx && a == FWG_LOCK_ADDR) lk = lk & d;
      if (ex) for (int i = 0; i < 512; i++) m[a / 512 * 512 + i] = 8'hFF;
      if (ex && a / 512 == 31) lk = 8'hFF;
   endtask
   task automatic boot();
      rst = 1'b1;
      repeat (5) @(negedge clk);
      rst = 1'b0;
      for (int i = 0; i < 8 && rdy !== 1'b1; i++) @(negedge clk);
      chk(rdy, 1'b1);
   endtask
   initial begin
      repeat (5000) @(posedge clk);
      error_cnt++;
      finish_test();
   end
   initial begin
      for (int i = 0; i < 2**FWG_ADDR_W; i++) m[i] = i[7:0] ^ 8'h5A;
      m[FWG_LOCK_ADDR] = LK0;
      lk = LK0;
      boot();
      // ==========================================================
      // Every enable combination, locked and unlocked targets
      for (int i = 0; i < 4; i++) begin
         {we, ee} = 2'(i);
         req(0, 14'h0800 + 14'(i), 8'hA5, 1'b0);
         req(0, 14'h0010 + 14'(i), 8'h0F, 1'b0);
         req(0, 14'h0020 + 14'(i), 8'h33, 1'b1);
         req(1, 14'h0010 + 14'(i), 8'h00, 1'b0);
      end
      $display("test 1 done");
      // ==========================================================
      // Page boundaries for code reads and every debug operation
      {we, ee} = 2'b00;
      foreach (BD[j]) for (int k = 2; k < 7; k++) begin
         req(k, BD[j], 8'h3C, 1'b0);
         req(k, BD[j], 8'h3C, 1'b1);
      end
      $display("test 2 done");
      // ==========================================================
      // Random mix of request kinds 0 to 5
      for (int i = 0; i < 60; i++) begin
         rs = xs(rs);
         {we, ee} = rs[23:22];
         req(int'(rs[18:16]) % 6, rs[13:0], rs[31:24], rs[20]);
      end
      $display("test 3 done");
      // ==========================================================
      // Lock page erased, then a second reset rereads an all-ones byte
      {we, ee} = 2'b11;
      req(0, 14'h3E00, 8'h00, 1'b1);
      boot();
      req(2, 14'h0000, 8'h00, 1'b0);
      req(3, FWG_LOCK_ADDR, 8'h00, 1'b0);
      $display("test 4 done");
      finish_test();
   end
endmodule
